/* verilog/tul_panel_top.sv */
// Operator panel load-point and ON-lamp control with an APB register slave.
// Overview of operation
// - The load-point lamp goes out whenever the marker leaves the detector.
// - At the marker under program control, the control unit's forward signal moves tape forward and so clears the lamp.
// - Holding the forward or tape removal switch at the marker under manual control moves tape off and clears the lamp.
// - The off switch or a vacuum column fault clears the load-point lamp.
// - A marker passing while forward or tape removal is held lights the lamp only briefly.
// - Load point pressed with manual and ON lamps lit lights the forward lamp and starts a search.
// - The search runs forward at 42.7 inches per second.
// - The search stops at the marker, then the manual lamp goes out and the program lamp lights.
// - ON, off or a vacuum column fault aborts the search.
// - Load point pressed at the marker moves nothing but hands over to program control.
// - Load point pressed during rewind backward motion turns it into a rewind to the marker.
// - The ON lamp is lit only while motors run, columns are loaded and the unit is ready.
// - The ON lamp lights on an ON switch press once tape is loaded in both columns and within operating range.
// - Pressing the ON switch while loading is not stored, so the ON lamp stays dark.
// - The load-point lamp lights while the marker is under the detector and ON is lit.
//
// The APB register port and the address map were chosen for this implementation.
`default_nettype none
module tul_panel_top (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic reset_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Tape sensors and control unit signals.
    input wire logic marker_i,
    input wire logic col_out_i,
    input wire logic col_over_i,
    input wire logic motors_run_i,
    input wire logic cols_loaded_i,
    input wire logic in_range_i,
    input wire logic cu_fwd_i,
    input wire logic cu_op_start_i,
    input wire logic rewind_back_i,
    // Operator switches.
    input wire logic sw_fwd_i,
    input wire logic tape_removal_switch_i,
    input wire logic sw_off_i,
    input wire logic sw_on_i,
    input wire logic sw_load_point_i,
    // Lamps.
    output logic on_lamp_o,
    output logic bot_lamp_o,
    output logic manual_lamp_o,
    output logic program_lamp_o,
    output logic fwd_lamp_o,
    // Motion commands and interrupt.
    output logic motion_fwd_o,
    output logic search_o,
    output logic [15:0] motion_speed_o,
    output logic rewind_to_bot_o,
    output logic irq_o
);
    import tul_pkg::*;

    typedef struct packed {
        logic [TUL_NIN-1:0] prev;
        logic armed;
        logic on;
        logic bot;
        logic manual;
        logic fwd_lamp;
        logic search;
        logic rw_bot;
        logic mot_fwd;
        logic [15:0] speed;
        logic soft_off;
        logic [TUL_NEV-1:0] irq;
        logic [TUL_NEV-1:0] mask;
        logic [31:0] prdata;
    } tul_state_t;

    tul_state_t st_r;
    tul_state_t st_nxt;
    logic [TUL_NIN-1:0] in_s;
    logic lp_press;
    logic on_press;
    logic off_req;
    logic fault;
    logic ready;
    logic [TUL_NEV-1:0] ev;
    logic apb_setup;
    logic apb_wr;
    logic addr_ok;

    tul_sync_if #(.W(TUL_NIN)) sync_bus ();

    // Every panel and sensor pin comes from outside the clock domain and is synchronised; the APB pins are not.
    assign sync_bus.raw = {rewind_back_i, cu_op_start_i, cu_fwd_i, in_range_i, cols_loaded_i,
                           motors_run_i, col_over_i, col_out_i, sw_load_point_i, sw_on_i,
                           sw_off_i, tape_removal_switch_i, sw_fwd_i, marker_i};
    assign in_s = sync_bus.clean;

    tul_in_sync #(.W(TUL_NIN)) u_sync (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .sif(sync_bus.sync)
    );

    // Decoded panel events and conditions.
    assign lp_press = in_s[TUL_IN_SW_LP] & ~st_r.prev[TUL_IN_SW_LP];
    assign on_press = in_s[TUL_IN_SW_ON] & ~st_r.prev[TUL_IN_SW_ON];
    assign off_req = in_s[TUL_IN_SW_OFF] | st_r.soft_off;
    assign fault = in_s[TUL_IN_COL_OUT] | in_s[TUL_IN_COL_OVER];
    assign ready = in_s[TUL_IN_MOTORS] & in_s[TUL_IN_LOADED] & in_s[TUL_IN_RANGE];
    assign apb_setup = psel_i & ~penable_i;
    assign apb_wr = psel_i & penable_i & pwrite_i;
    assign addr_ok = (paddr_i == TUL_CTRL_OFS) || (paddr_i == TUL_STATUS_OFS) ||
                     (paddr_i == TUL_IRQ_STAT_OFS) || (paddr_i == TUL_IRQ_MASK_OFS);

    // Next-state logic for lamps, search, rewind conversion and registers.
    always_comb begin
        st_nxt = st_r;
        ev = '0;
        st_nxt.prev = in_s;
        // The ON switch arms the unit; off or a column fault disarms it.
        if (off_req || fault || !ready) begin
            st_nxt.armed = 1'b0;
        end else if (on_press) begin
            st_nxt.armed = 1'b1;
        end
        st_nxt.on = st_nxt.armed & ready;
        // Load-point lamp follows the marker while ON is lit.
        st_nxt.bot = st_nxt.on & in_s[TUL_IN_MARKER] & ~off_req & ~fault;

        // Mode and search control.
        // A search is dropped in the very cycle that ON goes out, so its abort event is kept.
        if (st_r.search && (on_press || off_req || fault || !st_nxt.on)) begin
            st_nxt.search = 1'b0;
            ev[TUL_EV_ABORT_BIT] = 1'b1;
        end else if (st_r.search && in_s[TUL_IN_MARKER]) begin
            st_nxt.search = 1'b0;
            st_nxt.manual = 1'b0;
            ev[TUL_EV_DONE_BIT] = 1'b1;
        end else if (on_press && st_r.on) begin
            st_nxt.manual = 1'b1;
            st_nxt.fwd_lamp = 1'b1;
            st_nxt.rw_bot = 1'b0;
        end else if (lp_press && st_r.on && in_s[TUL_IN_REWIND]) begin
            st_nxt.rw_bot = 1'b1;
            st_nxt.fwd_lamp = 1'b0;
        end else if (lp_press && st_r.on && st_r.manual && !st_r.search) begin
            if (in_s[TUL_IN_MARKER]) begin
                st_nxt.manual = 1'b0;
            end else begin
                st_nxt.search = 1'b1;
                st_nxt.fwd_lamp = 1'b1;
            end
        end else if (st_r.rw_bot && in_s[TUL_IN_MARKER]) begin
            st_nxt.rw_bot = 1'b0;
            st_nxt.manual = 1'b0;
        end
        // No motion request survives the ON lamp going out, not even a search started now.
        if (!st_nxt.on) begin
            st_nxt.rw_bot = 1'b0;
            st_nxt.search = 1'b0;
        end

        // Forward motion: search, held switches in manual, control unit in program.
        st_nxt.mot_fwd = st_nxt.on & (st_nxt.search |
            (st_r.manual & (in_s[TUL_IN_SW_FWD] | in_s[TUL_IN_SW_REMOVAL])) |
            (~st_r.manual & in_s[TUL_IN_CU_FWD]));
        st_nxt.speed = st_nxt.search ? TUL_SEARCH_CIPS : 16'h0000;
        // Interrupt events.
        ev[TUL_EV_BOT_BIT] = st_nxt.bot & ~st_r.bot;
        ev[TUL_EV_ONLOST_BIT] = st_r.on & ~st_nxt.on;
        // Register writes; a new event wins over a write-one-to-clear.
        if (apb_wr && paddr_i == TUL_CTRL_OFS) begin
            st_nxt.soft_off = pwdata_i[TUL_CTRL_SOFT_OFF_BIT];
        end
        if (apb_wr && paddr_i == TUL_IRQ_MASK_OFS) begin
            st_nxt.mask = pwdata_i[TUL_NEV-1:0];
        end
        if (apb_wr && paddr_i == TUL_IRQ_STAT_OFS) begin
            st_nxt.irq = (st_r.irq & ~pwdata_i[TUL_NEV-1:0]) | ev;
        end else begin
            st_nxt.irq = st_r.irq | ev;
        end
        // Read data is captured in the setup phase for a zero-wait access.
        if (apb_setup) begin
            st_nxt.prdata = 32'h0000_0000;
            case (paddr_i)
                TUL_CTRL_OFS: begin
                    st_nxt.prdata[TUL_CTRL_SOFT_OFF_BIT] = st_r.soft_off;
                end
                TUL_STATUS_OFS: begin
                    st_nxt.prdata[TUL_ST_ON_BIT] = st_r.on;
                    st_nxt.prdata[TUL_ST_BOT_BIT] = st_r.bot;
                    st_nxt.prdata[TUL_ST_MANUAL_BIT] = st_r.manual;
                    st_nxt.prdata[TUL_ST_PROGRAM_BIT] = ~st_r.manual;
                    st_nxt.prdata[TUL_ST_FWD_LAMP_BIT] = st_r.fwd_lamp;
                    st_nxt.prdata[TUL_ST_SEARCH_BIT] = st_r.search;
                    st_nxt.prdata[TUL_ST_RW_BOT_BIT] = st_r.rw_bot;
                    st_nxt.prdata[TUL_ST_MOT_FWD_BIT] = st_r.mot_fwd;
                end
                TUL_IRQ_STAT_OFS: begin
                    st_nxt.prdata[TUL_NEV-1:0] = st_r.irq;
                end
                TUL_IRQ_MASK_OFS: begin
                    st_nxt.prdata[TUL_NEV-1:0] = st_r.mask;
                end
                default: begin
                    st_nxt.prdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // State register; the unit powers up in manual control with all motion stopped.
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            st_r <= '0;
            st_r.manual <= 1'b1;
            st_r.fwd_lamp <= 1'b1;
            st_r.soft_off <= TUL_CTRL_RST;
            st_r.irq <= TUL_IRQ_RST;
            st_r.mask <= TUL_MASK_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs.
    assign prdata_o = st_r.prdata;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~addr_ok;
    assign on_lamp_o = st_r.on;
    assign bot_lamp_o = st_r.bot;
    assign manual_lamp_o = st_r.manual;
    assign program_lamp_o = ~st_r.manual;
    assign fwd_lamp_o = st_r.fwd_lamp;
    assign motion_fwd_o = st_r.mot_fwd;
    assign search_o = st_r.search;
    assign motion_speed_o = st_r.speed;
    assign rewind_to_bot_o = st_r.rw_bot;
    assign irq_o = |(st_r.irq & st_r.mask);

    // Load-point lamp checks: it follows the marker, needs ON and yields to faults.
    a_bot_follow_marker: assert property (@(posedge mclk_i) disable iff (reset_i)
        !in_s[TUL_IN_MARKER] |=> !bot_lamp_o) else $error("load lamp lit without marker");
    a_bot_needs_on: assert property (@(posedge mclk_i) disable iff (reset_i)
        bot_lamp_o |-> on_lamp_o) else $error("load lamp lit without ON lamp");
    a_bot_cleared_fault: assert property (@(posedge mclk_i) disable iff (reset_i)
        (fault || off_req) |=> !bot_lamp_o) else $error("load lamp survived fault or off");

    // Search checks: start, speed, hand-over at the marker and the ON, off and fault abort causes.
    a_search_start: assert property (@(posedge mclk_i) disable iff (reset_i)
        (lp_press && on_lamp_o && manual_lamp_o && !search_o && !in_s[TUL_IN_MARKER] &&
         !in_s[TUL_IN_REWIND] && !on_press && ready && !off_req && !fault)
        |=> search_o && fwd_lamp_o) else $error("search did not start");
    a_search_speed: assert property (@(posedge mclk_i) disable iff (reset_i)
        search_o |-> motion_fwd_o && motion_speed_o == TUL_SEARCH_CIPS)
        else $error("search speed wrong");
    a_search_done: assert property (@(posedge mclk_i) disable iff (reset_i)
        (search_o && in_s[TUL_IN_MARKER] && !on_press && !off_req && !fault && on_lamp_o && ready)
        |=> !search_o && program_lamp_o) else $error("search did not hand over");
    a_search_abort: assert property (@(posedge mclk_i) disable iff (reset_i)
        (search_o && (on_press || off_req || fault)) |=> !search_o && !motion_fwd_o)
        else $error("search not aborted");
    a_search_needs_on: assert property (@(posedge mclk_i) disable iff (reset_i)
        search_o |-> on_lamp_o) else $error("search running without ON lamp");

    // Load point pressed at the marker and during a rewind.
    a_lp_at_marker: assert property (@(posedge mclk_i) disable iff (reset_i)
        (lp_press && on_lamp_o && manual_lamp_o && !search_o && in_s[TUL_IN_MARKER] &&
         !in_s[TUL_IN_REWIND] && !on_press) |=> program_lamp_o && !search_o)
        else $error("load point at marker did not hand over");
    a_rewind_convert: assert property (@(posedge mclk_i) disable iff (reset_i)
        (lp_press && on_lamp_o && in_s[TUL_IN_REWIND] && !search_o && !on_press && ready &&
         !off_req && !fault) |=> rewind_to_bot_o) else $error("rewind not converted");

    // ON lamp checks.
    a_on_needs_ready: assert property (@(posedge mclk_i) disable iff (reset_i)
        !ready |=> !on_lamp_o) else $error("ON lamp lit while not ready");
    a_on_switch_lights: assert property (@(posedge mclk_i) disable iff (reset_i)
        (on_press && ready && !off_req && !fault) |=> on_lamp_o)
        else $error("ON switch did not light lamp");

    // Motion commands from held switches and from the control unit.
    a_hold_moves: assert property (@(posedge mclk_i) disable iff (reset_i)
        (manual_lamp_o && on_lamp_o && ready && !off_req && !fault && !on_press &&
         in_s[TUL_IN_SW_FWD]) |=> motion_fwd_o) else $error("forward switch did not move");
    a_cu_moves: assert property (@(posedge mclk_i) disable iff (reset_i)
        (program_lamp_o && on_lamp_o && ready && !off_req && !fault && !on_press &&
         in_s[TUL_IN_CU_FWD]) |=> motion_fwd_o) else $error("control unit forward ignored");

    // Mode lamps change only on an ON press or on a hand-over to program control.
    a_manual_by_on: assert property (@(posedge mclk_i) disable iff (reset_i)
        $rose(manual_lamp_o) |-> $past(on_press))
        else $error("manual lamp lit without ON press");
    a_program_by_lp: assert property (@(posedge mclk_i) disable iff (reset_i)
        $rose(program_lamp_o) |-> $past(lp_press) || $past(search_o) || $past(rewind_to_bot_o))
        else $error("program lamp lit without hand-over");
    a_on_to_manual: assert property (@(posedge mclk_i) disable iff (reset_i)
        (on_press && on_lamp_o && !search_o && ready && !off_req && !fault)
        |=> manual_lamp_o && fwd_lamp_o) else $error("ON press did not return to manual");
endmodule : tul_panel_top
`default_nettype wire

/* verilog/tul_pkg.sv */
// Package of register map, input indices and reset values for the tape panel block.
`default_nettype none
package tul_pkg;
    // Register byte offsets.
    localparam logic [7:0] TUL_CTRL_OFS = 8'h00;
    localparam logic [7:0] TUL_STATUS_OFS = 8'h04;
    localparam logic [7:0] TUL_IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] TUL_IRQ_MASK_OFS = 8'h0c;
    // Control register field.
    localparam int TUL_CTRL_SOFT_OFF_BIT = 0;
    // Status register fields.
    localparam int TUL_ST_ON_BIT = 0;
    localparam int TUL_ST_BOT_BIT = 1;
    localparam int TUL_ST_MANUAL_BIT = 2;
    localparam int TUL_ST_PROGRAM_BIT = 3;
    localparam int TUL_ST_FWD_LAMP_BIT = 4;
    localparam int TUL_ST_SEARCH_BIT = 5;
    localparam int TUL_ST_RW_BOT_BIT = 6;
    localparam int TUL_ST_MOT_FWD_BIT = 7;
    // Interrupt event bits.
    localparam int TUL_EV_BOT_BIT = 0;
    localparam int TUL_EV_DONE_BIT = 1;
    localparam int TUL_EV_ABORT_BIT = 2;
    localparam int TUL_EV_ONLOST_BIT = 3;
    localparam int TUL_NEV = 4;
    // Reset values.
    localparam logic TUL_CTRL_RST = 1'b0;
    localparam logic [TUL_NEV-1:0] TUL_IRQ_RST = 4'h0;
    localparam logic [TUL_NEV-1:0] TUL_MASK_RST = 4'h0;
    // Search speed in hundredths of an inch per second (42.7 in/s).
    localparam logic [15:0] TUL_SEARCH_CIPS = 16'h10ae;
    // Indices of the synchronised panel and sensor inputs.
    localparam int TUL_IN_MARKER = 0;
    localparam int TUL_IN_SW_FWD = 1;
    localparam int TUL_IN_SW_REMOVAL = 2;
    localparam int TUL_IN_SW_OFF = 3;
    localparam int TUL_IN_SW_ON = 4;
    localparam int TUL_IN_SW_LP = 5;
    localparam int TUL_IN_COL_OUT = 6;
    localparam int TUL_IN_COL_OVER = 7;
    localparam int TUL_IN_MOTORS = 8;
    localparam int TUL_IN_LOADED = 9;
    localparam int TUL_IN_RANGE = 10;
    localparam int TUL_IN_CU_FWD = 11;
    localparam int TUL_IN_CU_START = 12;
    localparam int TUL_IN_REWIND = 13;
    localparam int TUL_NIN = 14;
endpackage : tul_pkg
`default_nettype wire

/* verilog/tul_sync_if.sv */
// Interface carrying raw pins into the synchroniser and clean levels back.
`default_nettype none
interface tul_sync_if #(parameter int W = 14);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface : tul_sync_if
`default_nettype wire

/* verilog/tul_in_sync.sv */
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`default_nettype none
module tul_in_sync #(
    parameter int W = 14
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic reset_i,
    // Pins in, clean levels out.
    tul_sync_if.sync sif
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] clean;
    } tul_sync_st_t;

    tul_sync_st_t st_r;
    tul_sync_st_t st_nxt;

    // Stage one feeds only stage two; the filter looks at stages two and three.
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = sif.raw;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < W; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.clean[i] = st_r.s3[i];
            end
        end
    end

    // State register.
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sif.clean = st_r.clean;
endmodule : tul_in_sync
`default_nettype wire

/* dv/tul_tape_model.sv */
// Behavioural tape transport that turns motion commands into a marker detector level.
`default_nettype none
module tul_tape_model #(
    parameter int MARK_LO = 8,
    parameter int MARK_HI = 11,
    parameter int STEP = 4
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic reset_i,
    // Forward command from the panel block and rewind drive from the bench.
    input wire logic motion_fwd_i,
    input wire logic rewind_back_i,
    // Bench preset of the tape position.
    input wire logic load_i,
    input wire logic [7:0] load_pos_i,
    // Marker detector level.
    output logic marker_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] pos_r;
    int div;
    // Tape moves one position every STEP clocks; forward wins over rewind.
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            pos_r <= 8'h00;
            div <= 0;
        end else if (load_i) begin
            pos_r <= load_pos_i;
            div <= 0;
        end else if (motion_fwd_i || (rewind_back_i && pos_r != 8'h00)) begin
            div <= (div == STEP - 1) ? 0 : div + 1;
            if (div == STEP - 1) begin
                pos_r <= motion_fwd_i ? pos_r + 8'h01 : pos_r - 8'h01;
            end
        end
    end
    // The strip is seen only while it spans the detector.
    assign marker_o = (int'(pos_r) >= MARK_LO) && (int'(pos_r) <= MARK_HI);
endmodule : tul_tape_model
`default_nettype wire

/* dv/test_tape_unit_panel_load_point_control.sv */
// Self-checking bench for the tape panel block: registers, lamps, search, aborts, rewind.
`default_nettype none
module test_tape_unit_panel_load_point_control;
    timeunit 1ns;
    timeprecision 1ps;
    import tul_pkg::*;
    localparam int SW_FWD = 0, SW_REM = 1, SW_OFF = 2, SW_ON = 3, SW_LP = 4;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, pos_val = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, marker, load = 1'b0;
    logic col_out = 1'b0, col_over = 1'b0, motors = 1'b0, loaded = 1'b0, in_range = 1'b0;
    logic cu_fwd = 1'b0, cu_start = 1'b0, rew_back = 1'b0;
    logic [4:0] sw = 5'h00;
    logic on_l, bot_l, man_l, prg_l, fwd_l, mot_f, srch, rw_bot, irq;
    logic [15:0] speed;
    int bad_count = 0, checks = 0, cyc = 0;
    tul_panel_top dut (.mclk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .marker_i(marker), .col_out_i(col_out),
        .col_over_i(col_over), .motors_run_i(motors), .cols_loaded_i(loaded),
        .in_range_i(in_range), .cu_fwd_i(cu_fwd), .cu_op_start_i(cu_start),
        .rewind_back_i(rew_back), .sw_fwd_i(sw[SW_FWD]), .tape_removal_switch_i(sw[SW_REM]),
        .sw_off_i(sw[SW_OFF]), .sw_on_i(sw[SW_ON]), .sw_load_point_i(sw[SW_LP]),
        .on_lamp_o(on_l), .bot_lamp_o(bot_l), .manual_lamp_o(man_l), .program_lamp_o(prg_l),
        .fwd_lamp_o(fwd_l), .motion_fwd_o(mot_f), .search_o(srch), .motion_speed_o(speed),
        .rewind_to_bot_o(rw_bot), .irq_o(irq));
    tul_tape_model tape (.mclk_i(clk), .reset_i(rst), .motion_fwd_i(mot_f),
        .rewind_back_i(rew_back), .load_i(load), .load_pos_i(pos_val), .marker_o(marker));
    // Clock of 4 ns period.
    initial forever #2 clk = ~clk;
    // Prints the counts and the verdict, then stops the run.
    task automatic end_of_test();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test
    // Hang guard well above the length of the whole sequence.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count++;
            end_of_test();
        end
    end
    // Compares one value and reports a mismatch at once.
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // One APB transfer; read data and error are taken at the edge that sees pready.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Presses and releases one panel switch, long enough for the synchroniser.
    task automatic press(input int b);
        @(posedge clk);
        sw[b] <= 1'b1;
        tick(8);
        sw[b] <= 1'b0;
        tick(8);
    endtask : press
    task automatic place(input logic [7:0] p);
        @(posedge clk);
        load <= 1'b1;
        pos_val <= p;
        @(posedge clk);
        load <= 1'b0;
        tick(8);
    endtask : place
    // Brings the unit to ON lit under manual control.
    task automatic arm();
        if (on_l !== 1'b1) press(SW_ON);
        if (prg_l !== 1'b0) press(SW_ON);
        check("manual ready", 2'b11, {on_l, man_l});
    endtask : arm
    // Applies one abort or clearing cause: off, ON, column overrun, column loss, soft off.
    task automatic fault(input int k);
        if (k < 2) begin
            press(k == 0 ? SW_OFF : SW_ON);
        end else if (k < 4) begin
            @(posedge clk);
            col_over <= (k == 2);
            col_out <= (k == 3);
            tick(8);
            col_over <= 1'b0;
            col_out <= 1'b0;
            tick(8);
        end else begin
            apb(1'b1, TUL_CTRL_OFS, 32'h1);
            tick(8);
            apb(1'b1, TUL_CTRL_OFS, 32'h0);
        end
    endtask : fault
    // Reset state of lamps and registers, and an unmapped access.
    task automatic t_reset();
        check("reset lamps", 5'b00011, {on_l, bot_l, prg_l, man_l, fwd_l});
        apb(1'b0, TUL_STATUS_OFS, 32'h0);
        check("status reset", 32'h14, rd);
        apb(1'b0, TUL_IRQ_MASK_OFS, 32'h0);
        check("mask reset", 32'h0, rd);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, rd);
    endtask : t_reset
    // ON lamp needs the ON press and goes out when the motors stop.
    task automatic t_on();
        @(posedge clk);
        motors <= 1'b1;
        loaded <= 1'b1;
        in_range <= 1'b1;
        tick(8);
        check("on before press", 1'b0, on_l);
        press(SW_ON);
        check("on after press", 1'b1, on_l);
        motors <= 1'b0;
        tick(8);
        check("on motors stopped", 1'b0, on_l);
        apb(1'b0, TUL_IRQ_STAT_OFS, 32'h0);
        check("on lost event", 1'b1, rd[TUL_EV_ONLOST_BIT]);
        apb(1'b1, TUL_IRQ_STAT_OFS, 32'hf);
        motors <= 1'b1;
        arm();
    endtask : t_on
    // Load-point search to the marker, hand-over and the done interrupt.
    task automatic t_search();
        place(8'h00);
        apb(1'b1, TUL_IRQ_MASK_OFS, 32'h2);
        @(posedge clk);
        sw[SW_LP] <= 1'b1;
        tick(6);
        check("search start", 4'hf, {srch, mot_f, fwd_l, man_l});
        check("search speed", 16'h10ae, speed);
        sw[SW_LP] <= 1'b0;
        for (int i = 0; i < 300 && srch !== 1'b0; i++) @(posedge clk);
        tick(2);
        check("search end", 4'b0011, {mot_f, man_l, prg_l, bot_l});
        check("done irq", 1'b1, irq);
        apb(1'b1, TUL_IRQ_STAT_OFS, 32'h2);
        tick(2);
        check("irq cleared", 1'b0, irq);
    endtask : t_search
    // Control unit forward motion under program control moves tape off the marker.
    task automatic t_cu();
        @(posedge clk);
        cu_fwd <= 1'b1;
        cu_start <= 1'b1;
        for (int i = 0; i < 200 && bot_l !== 1'b0; i++) @(posedge clk);
        check("cu forward", 2'b10, {mot_f, bot_l});
        cu_fwd <= 1'b0;
        cu_start <= 1'b0;
        tick(8);
    endtask : t_cu
    // Hand-over at the marker, forward switch off the marker, blink while passing.
    task automatic t_manual();
        arm();
        place(8'h09);
        check("lamp at marker", 1'b1, bot_l);
        @(posedge clk);
        sw[SW_LP] <= 1'b1;
        tick(6);
        check("no motion at marker", 2'b00, {mot_f, srch});
        sw[SW_LP] <= 1'b0;
        tick(8);
        check("handover", 2'b01, {man_l, prg_l});
        arm();
        sw[SW_FWD] <= 1'b1;
        for (int i = 0; i < 200 && bot_l !== 1'b0; i++) @(posedge clk);
        check("forward off marker", 1'b0, bot_l);
        sw[SW_FWD] <= 1'b0;
        place(8'h04);
        sw[SW_REM] <= 1'b1;
        for (int i = 0; i < 100 && bot_l !== 1'b1; i++) @(posedge clk);
        check("blink on", 1'b1, bot_l);
        for (int i = 0; i < 100 && bot_l !== 1'b0; i++) @(posedge clk);
        check("blink off", 1'b0, bot_l);
        sw[SW_REM] <= 1'b0;
        tick(8);
    endtask : t_manual
    // Off, ON and both column faults stop a search, then clearing causes at the marker.
    task automatic t_abort();
        for (int k = 0; k < 4; k++) begin
            arm();
            place(8'h00);
            @(posedge clk);
            sw[SW_LP] <= 1'b1;
            tick(6);
            sw[SW_LP] <= 1'b0;
            check("search running", 1'b1, srch);
            fault(k);
            check("search aborted", 2'b00, {srch, mot_f});
            apb(1'b0, TUL_IRQ_STAT_OFS, 32'h0);
            check("abort event", 1'b1, rd[TUL_EV_ABORT_BIT]);
            apb(1'b1, TUL_IRQ_STAT_OFS, 32'hf);
        end
        for (int k = 0; k < 5; k++) begin
            arm();
            place(8'h09);
            check("lamp before clear", 1'b1, bot_l);
            fault(k);
            if (k != 1) check("lamp cleared", 1'b0, bot_l);
        end
    endtask : t_abort
    // Load point during rewind turns it into a rewind to the marker.
    task automatic t_rewind();
        arm();
        place(8'h28);
        rew_back <= 1'b1;
        press(SW_LP);
        check("rewind converted", 1'b1, rw_bot);
        for (int i = 0; i < 400 && prg_l !== 1'b1; i++) @(posedge clk);
        check("rewind handover", 2'b01, {man_l, prg_l});
        rew_back <= 1'b0;
        tick(8);
    endtask : t_rewind
    // Main sequence.
    initial begin
        tick(3);
        rst <= 1'b0;
        tick(2);
        t_reset();
        t_on();
        t_search();
        t_cu();
        t_manual();
        t_abort();
        t_rewind();
        end_of_test();
    end
endmodule : test_tape_unit_panel_load_point_control
`default_nettype wire
